// file: core/cta_cache_test.sv
// Cache array with test register access path
`timescale 1ns/1ps
`default_nettype none
module cta_cache_test (
  // Clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      resetn_i,
  // Test register port
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  input  wire cta_pkg::cta_sel_t         reg_sel_i,
  input  wire logic [31:0]               reg_wdata_i,
  output logic                           reg_ready_o,
  output logic                           reg_rvalid_o,
  output logic [31:0]                    reg_rdata_o,
  // Normal cache access port
  input  wire logic                      core_req_i,
  input  wire cta_pkg::cta_core_req_t    core_i,
  output logic                           core_ready_o,
  output logic                           core_rvalid_o,
  output logic                           core_hit_o,
  output logic [cta_pkg::CTA_DATA_W-1:0] core_rdata_o
);

  localparam int unsigned WAYS = cta_pkg::CTA_WAYS;
  localparam int unsigned DWS  = cta_pkg::CTA_DWORDS;
  localparam int unsigned IW   = cta_pkg::CTA_IDX_W;
  localparam int unsigned TW   = cta_pkg::CTA_TAG_W;
  localparam int unsigned DW   = cta_pkg::CTA_DATA_W;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TRD  = 3'b010,
    ST_CRD  = 3'b100
  } cta_state_t;

  cta_state_t           state_q;
  cta_pkg::cta_ctrl_t   ctrl_q;
  cta_pkg::cta_ctrl_t   ctrl_new;
  cta_pkg::cta_tagreg_t tagr_q;
  cta_pkg::cta_tagreg_t tag_new;
  logic [DW-1:0]        fill_q  [DWS];
  logic [DW-1:0]        flush_q [DWS];
  logic                 valid_q [WAYS][cta_pkg::CTA_LINES];
  logic [DWS-1:0]       dirty_q [WAYS][cta_pkg::CTA_LINES];
  logic [2:0]           lru_q   [cta_pkg::CTA_LINES];
  logic [1:0]           rd_way_q;
  logic [1:0]           rd_dw_q;
  logic [IW-1:0]        rd_idx_q;
  logic [TW-1:0]        rd_tag_q;
  logic [31:0]          reg_rdata_q;
  logic                 reg_rvalid_q;
  logic [DW-1:0]        core_rdata_q;
  logic                 core_rvalid_q;
  logic                 core_hit_q;

  logic                 idle;
  logic                 ctrl_wr;
  logic                 tag_wr;
  logic                 data_wr;
  logic                 core_go;
  logic                 test_wr;
  logic                 test_rd;
  logic                 test_fl;
  logic [IW-1:0]        mem_addr;
  logic [WAYS-1:0]      tag_we;
  logic [DWS-1:0]       data_we [WAYS];
  logic [DW-1:0]        data_wd [DWS];
  logic [TW-1:0]        tag_rd  [WAYS];
  logic [DW-1:0]        data_rd [WAYS][DWS];

  // Pseudo-LRU update on an access to a way
  function automatic logic [2:0] lru_upd(input logic [2:0] cur, input logic [1:0] way);
    logic [2:0] n;
    n = cur;
    n[0] = ~way[1];
    if (!way[1]) begin
      n[1] = ~way[0];
    end else begin
      n[2] = ~way[0];
    end
    return n;
  endfunction

  // Request decode
  assign idle         = (state_q == ST_IDLE);
  assign reg_ready_o  = idle;
  assign ctrl_wr      = reg_wr_i & idle & (reg_sel_i == cta_pkg::CTA_SEL_CTRL);
  assign tag_wr       = reg_wr_i & idle & (reg_sel_i == cta_pkg::CTA_SEL_TAG);
  assign data_wr      = reg_wr_i & idle & (reg_sel_i == cta_pkg::CTA_SEL_DATA);
  assign ctrl_new     = cta_pkg::cta_ctrl_t'(reg_wdata_i & cta_pkg::CTA_CTRL_WMASK);
  assign tag_new      = cta_pkg::cta_tagreg_t'(reg_wdata_i & cta_pkg::CTA_TAG_WMASK);
  assign test_wr      = ctrl_wr & (ctrl_new.op == cta_pkg::CTA_OP_CWR);
  assign test_rd      = ctrl_wr & (ctrl_new.op == cta_pkg::CTA_OP_CRD);
  assign test_fl      = ctrl_wr & (ctrl_new.op == cta_pkg::CTA_OP_FLUSH);
  // Register writes lock out normal accesses for the cycle
  assign core_ready_o = idle & ~reg_wr_i;
  assign core_go      = core_req_i & core_ready_o;

  // Memory address and write enables
  always_comb begin
    mem_addr = core_go ? core_i.index : ctrl_new.line;
    for (int w = 0; w < WAYS; w++) begin
      tag_we[w] = test_wr & (ctrl_new.sel == w[1:0]);
      for (int d = 0; d < DWS; d++) begin
        data_we[w][d] = (test_wr & (ctrl_new.sel == w[1:0])) |
                        (core_go & core_i.we & (core_i.way == w[1:0]) & (core_i.dword == d[1:0]));
      end
    end
    for (int d = 0; d < DWS; d++) begin
      data_wd[d] = core_go ? core_i.wdata : fill_q[d];
    end
  end

  // Tag and data arrays
  for (genvar gw = 0; gw < WAYS; gw++) begin : g_way
    cta_sram #(.WIDTH(TW), .DEPTH(cta_pkg::CTA_LINES), .AW(IW)) u_tag (
      .sys_clk_i (sys_clk_i),
      .resetn_i  (resetn_i),
      .we_i      (tag_we[gw]),
      .addr_i    (mem_addr),
      .wdata_i   (tagr_q.tag),
      .rdata_o   (tag_rd[gw])
    );
    for (genvar gd = 0; gd < DWS; gd++) begin : g_dw
      cta_sram #(.WIDTH(DW), .DEPTH(cta_pkg::CTA_LINES), .AW(IW)) u_data (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .we_i      (data_we[gw][gd]),
        .addr_i    (mem_addr),
        .wdata_i   (data_wd[gd]),
        .rdata_o   (data_rd[gw][gd])
      );
    end
  end

  // Sequencer
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (test_rd) begin
            state_q <= ST_TRD;
          end else if (core_go && !core_i.we) begin
            state_q <= ST_CRD;
          end
        end
        ST_TRD: begin
          state_q <= ST_IDLE;
        end
        ST_CRD: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Pending read context
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_way_q <= 2'h0;
      rd_dw_q  <= 2'h0;
      rd_idx_q <= '0;
      rd_tag_q <= '0;
    end else if (test_rd) begin
      rd_way_q <= ctrl_new.sel;
      rd_idx_q <= ctrl_new.line;
    end else if (core_go) begin
      rd_way_q <= core_i.way;
      rd_dw_q  <= core_i.dword;
      rd_idx_q <= core_i.index;
      rd_tag_q <= core_i.tag;
    end
  end

  // Control register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= cta_pkg::cta_ctrl_t'(cta_pkg::CTA_CTRL_RST);
    end else if (ctrl_wr) begin
      ctrl_q <= ctrl_new;
    end
  end

  // Tag register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tagr_q <= cta_pkg::cta_tagreg_t'(cta_pkg::CTA_TAG_RST);
    end else if (tag_wr) begin
      tagr_q.tag   <= tag_new.tag;
      tagr_q.valid <= tag_new.valid;
      tagr_q.dirty <= tag_new.dirty;
    end else if (state_q == ST_TRD) begin
      tagr_q.tag   <= tag_rd[rd_way_q];
      tagr_q.valid <= valid_q[rd_way_q][rd_idx_q];
      tagr_q.dirty <= dirty_q[rd_way_q][rd_idx_q];
      tagr_q.lru   <= lru_q[rd_idx_q];
    end
  end

  // Fill buffer
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int d = 0; d < DWS; d++) begin
        fill_q[d] <= cta_pkg::CTA_DATA_RST;
      end
    end else if (data_wr && ctrl_q.op == cta_pkg::CTA_OP_BUF) begin
      fill_q[ctrl_q.sel] <= reg_wdata_i;
    end
  end

  // Flush buffer
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int d = 0; d < DWS; d++) begin
        flush_q[d] <= cta_pkg::CTA_DATA_RST;
      end
    end else if (state_q == ST_TRD) begin
      for (int d = 0; d < DWS; d++) begin
        flush_q[d] <= data_rd[rd_way_q][d];
      end
    end
  end

  // Valid bits
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int w = 0; w < WAYS; w++) begin
        for (int l = 0; l < cta_pkg::CTA_LINES; l++) begin
          valid_q[w][l] <= 1'b0;
        end
      end
    end else if (test_fl) begin
      for (int w = 0; w < WAYS; w++) begin
        for (int l = 0; l < cta_pkg::CTA_LINES; l++) begin
          valid_q[w][l] <= 1'b0;
        end
      end
    end else if (test_wr) begin
      valid_q[ctrl_new.sel][ctrl_new.line] <= tagr_q.valid;
    end
  end

  // Dirty bits, one per doubleword
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int w = 0; w < WAYS; w++) begin
        for (int l = 0; l < cta_pkg::CTA_LINES; l++) begin
          dirty_q[w][l] <= '0;
        end
      end
    end else if (test_wr) begin
      dirty_q[ctrl_new.sel][ctrl_new.line] <= tagr_q.dirty;
    end else if (core_go && core_i.we) begin
      dirty_q[core_i.way][core_i.index][core_i.dword] <= 1'b1;
    end
  end

  // Shared pseudo-LRU per line
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int l = 0; l < cta_pkg::CTA_LINES; l++) begin
        lru_q[l] <= cta_pkg::CTA_LRU_RST;
      end
    end else if (core_go) begin
      lru_q[core_i.index] <= lru_upd(lru_q[core_i.index], core_i.way);
    end
  end

  // Test register read data
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_q  <= cta_pkg::CTA_DATA_RST;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd_i;
      if (reg_rd_i) begin
        unique case (reg_sel_i)
          cta_pkg::CTA_SEL_CTRL: reg_rdata_q <= 32'(ctrl_q);
          cta_pkg::CTA_SEL_TAG:  reg_rdata_q <= 32'(tagr_q) & cta_pkg::CTA_TAG_RMASK;
          cta_pkg::CTA_SEL_DATA: begin
            reg_rdata_q <= (ctrl_q.op == cta_pkg::CTA_OP_BUF) ? flush_q[ctrl_q.sel] : '0;
          end
          default:               reg_rdata_q <= '0;
        endcase
      end
    end
  end

  // Normal read answer
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      core_rdata_q  <= '0;
      core_rvalid_q <= 1'b0;
      core_hit_q    <= 1'b0;
    end else begin
      core_rvalid_q <= (state_q == ST_CRD);
      if (state_q == ST_CRD) begin
        core_rdata_q <= data_rd[rd_way_q][rd_dw_q];
        core_hit_q   <= valid_q[rd_way_q][rd_idx_q] & (tag_rd[rd_way_q] == rd_tag_q);
      end
    end
  end

  assign reg_rdata_o   = reg_rdata_q;
  assign reg_rvalid_o  = reg_rvalid_q;
  assign core_rdata_o  = core_rdata_q;
  assign core_rvalid_o = core_rvalid_q;
  assign core_hit_o    = core_hit_q;

endmodule
`default_nettype wire

// file: inc/cta_pkg.sv
// Package for the cache array test access block: constants, fields and types
package cta_pkg;

  // Geometry
  localparam int unsigned CTA_WAYS    = 4;
  localparam int unsigned CTA_LINES   = 256;
  localparam int unsigned CTA_IDX_W   = 8;
  localparam int unsigned CTA_TAG_W   = 20;
  localparam int unsigned CTA_DATA_W  = 32;
  localparam int unsigned CTA_DWORDS  = 4;

  // Register field positions and masks
  localparam int unsigned CTA_CTRL_OP_LSB    = 0;
  localparam int unsigned CTA_CTRL_SEL_LSB   = 2;
  localparam int unsigned CTA_CTRL_LINE_LSB  = 4;
  localparam int unsigned CTA_TAG_DIRTY_LSB  = 3;
  localparam int unsigned CTA_TAG_LRU_LSB    = 7;
  localparam int unsigned CTA_TAG_VALID_BIT  = 10;
  localparam int unsigned CTA_TAG_ADDR_LSB   = 12;
  localparam logic [31:0] CTA_CTRL_WMASK     = 32'h0000_0FFF;
  localparam logic [31:0] CTA_TAG_WMASK      = 32'hFFFF_F478;
  localparam logic [31:0] CTA_TAG_RMASK      = 32'hFFFF_F7F8;

  // Reset values
  localparam logic [31:0] CTA_CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] CTA_TAG_RST   = 32'h0000_0000;
  localparam logic [31:0] CTA_DATA_RST  = 32'h0000_0000;
  localparam logic [2:0]  CTA_LRU_RST   = 3'h0;

  // Test register select
  typedef enum logic [1:0] {
    CTA_SEL_DATA = 2'h0,
    CTA_SEL_TAG  = 2'h1,
    CTA_SEL_CTRL = 2'h2
  } cta_sel_t;

  // Operation field codes
  typedef enum logic [1:0] {
    CTA_OP_BUF   = 2'h0,
    CTA_OP_CWR   = 2'h1,
    CTA_OP_CRD   = 2'h2,
    CTA_OP_FLUSH = 2'h3
  } cta_op_t;

  // Control register layout
  typedef struct packed {
    logic [19:0]          rsvd;
    logic [CTA_IDX_W-1:0] line;
    logic [1:0]           sel;
    cta_op_t              op;
  } cta_ctrl_t;

  // Tag register layout
  typedef struct packed {
    logic [CTA_TAG_W-1:0] tag;
    logic                 rsvd11;
    logic                 valid;
    logic [2:0]           lru;
    logic [3:0]           dirty;
    logic [2:0]           rsvd0;
  } cta_tagreg_t;

  // Normal cache access request
  typedef struct packed {
    logic                  we;
    logic [CTA_IDX_W-1:0]  index;
    logic [1:0]            way;
    logic [1:0]            dword;
    logic [CTA_TAG_W-1:0]  tag;
    logic [CTA_DATA_W-1:0] wdata;
  } cta_core_req_t;

endpackage

// file: core/cta_sram.sv
// Single-port memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module cta_sram #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 256,
  parameter int unsigned AW    = 8
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  // Access
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    addr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  output logic      [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // Storage
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
  end

  // Read register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_q[addr_i];
    end
  end

endmodule
`default_nettype wire

// file: tb/cta_cache_test_properties.sv
// Assertion checker for the cache test access block
`timescale 1ns/1ps
`default_nettype none
module cta_cache_test_properties (
  // Clock and reset
  input wire logic                           sys_clk_i,
  input wire logic                           resetn_i,
  // Test register port
  input wire logic                           reg_wr_i,
  input wire logic                           reg_rd_i,
  input wire cta_pkg::cta_sel_t              reg_sel_i,
  input wire logic [31:0]                    reg_wdata_i,
  input wire logic                           reg_ready_o,
  input wire logic                           reg_rvalid_o,
  input wire logic [31:0]                    reg_rdata_o,
  // Normal cache access port
  input wire logic                           core_req_i,
  input wire cta_pkg::cta_core_req_t         core_i,
  input wire logic                           core_ready_o,
  input wire logic                           core_rvalid_o,
  input wire logic                           core_hit_o,
  input wire logic [cta_pkg::CTA_DATA_W-1:0] core_rdata_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  logic crd_cmd;
  logic core_rd;
  assign crd_cmd = reg_wr_i && reg_ready_o && reg_sel_i == cta_pkg::CTA_SEL_CTRL && reg_wdata_i[1:0] == 2'h2;
  assign core_rd = core_req_i && core_ready_o && !core_i.we;
  AST_RD_ANSWER: assert property (reg_rd_i |=> reg_rvalid_o) else $error("Read answer missing");
  AST_RD_NO_EXTRA: assert property (!reg_rd_i |=> !reg_rvalid_o) else $error("Spurious read answer");
  AST_RDATA_HOLD: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o)) else $error("Read data moved");
  AST_TAG_RSVD: assert property (reg_rvalid_o && $past(reg_sel_i) == cta_pkg::CTA_SEL_TAG
    |-> reg_rdata_o[11] == 1'b0 && reg_rdata_o[2:0] == 3'h0) else $error("Tag reserved bits set");
  AST_CRD_STALL: assert property (crd_cmd |=> !reg_ready_o ##1 reg_ready_o) else $error("Cache read stall wrong");
  AST_TEST_BLOCKS_CORE: assert property (reg_wr_i |-> !core_ready_o) else $error("Core taken in test write");
  AST_CORE_RD_LAT: assert property (core_rd |=> !core_ready_o && !core_rvalid_o ##1 core_rvalid_o)
    else $error("Core read latency wrong");
  AST_CORE_PULSE: assert property (core_rvalid_o |=> !core_rvalid_o) else $error("Core answer too long");
  AST_CORE_HOLD: assert property (!core_rvalid_o |-> $stable(core_rdata_o) && $stable(core_hit_o))
    else $error("Core answer moved");
  COV_CRD: cover property (crd_cmd);
  COV_HIT: cover property (core_rd ##2 core_hit_o);
  COV_FLUSH: cover property (reg_wr_i && reg_sel_i == cta_pkg::CTA_SEL_CTRL && reg_wdata_i[1:0] == 2'h3);
endmodule
bind cta_cache_test cta_cache_test_properties u_cta_cache_test_properties (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_sel_i(reg_sel_i), .reg_wdata_i(reg_wdata_i), .reg_ready_o(reg_ready_o), .reg_rvalid_o(reg_rvalid_o),
  .reg_rdata_o(reg_rdata_o), .core_req_i(core_req_i), .core_i(core_i), .core_ready_o(core_ready_o),
  .core_rvalid_o(core_rvalid_o), .core_hit_o(core_hit_o), .core_rdata_o(core_rdata_o));
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the cache test access block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  localparam cta_pkg::cta_sel_t S_DA = cta_pkg::CTA_SEL_DATA;
  localparam cta_pkg::cta_sel_t S_TG = cta_pkg::CTA_SEL_TAG;
  localparam cta_pkg::cta_sel_t S_CT = cta_pkg::CTA_SEL_CTRL;
  localparam logic [19:0]       TAGV = 20'hA_BCDE;
  localparam logic [7:0]        LINE = 8'hA5;
  logic                         sys_clk_i   = 1'b0;
  logic                         resetn_i    = 1'b0;
  logic                         reg_wr_i    = 1'b0;
  logic                         reg_rd_i    = 1'b0;
  cta_pkg::cta_sel_t            reg_sel_i   = cta_pkg::CTA_SEL_DATA;
  logic [31:0]                  reg_wdata_i = 32'h0000_0000;
  logic                         core_req_i  = 1'b0;
  cta_pkg::cta_core_req_t       core_i      = '0;
  logic                         reg_ready_o, reg_rvalid_o, core_ready_o, core_rvalid_o, core_hit_o;
  logic [31:0]                  reg_rdata_o, core_rdata_o, v;
  int                           err_count   = 0;
  int                           checks_done = 0;
  logic [31:0]                  dw [4] = '{32'h1111_2222, 32'h3333_4444, 32'h5555_6666, 32'h7777_8888};
  always #50 sys_clk_i = ~sys_clk_i;
  cta_cache_test u_cta_cache_test (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_sel_i(reg_sel_i), .reg_wdata_i(reg_wdata_i), .reg_ready_o(reg_ready_o), .reg_rvalid_o(reg_rvalid_o),
    .reg_rdata_o(reg_rdata_o), .core_req_i(core_req_i), .core_i(core_i), .core_ready_o(core_ready_o),
    .core_rvalid_o(core_rvalid_o), .core_hit_o(core_hit_o), .core_rdata_o(core_rdata_o));
  task automatic end_sim();
    $display("Checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input cta_pkg::cta_sel_t s, input logic [31:0] d);
    @(negedge sys_clk_i);
    while (reg_ready_o !== 1'b1) @(negedge sys_clk_i);
    reg_sel_i = s;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input cta_pkg::cta_sel_t s, output logic [31:0] q);
    @(negedge sys_clk_i);
    reg_sel_i = s;
    reg_rd_i = 1'b1;
    @(negedge sys_clk_i);
    reg_rd_i = 1'b0;
    `CHK(reg_rvalid_o, 1'b1)
    q = reg_rdata_o;
  endtask
  task automatic crd(input logic [1:0] wy);
    wr(S_CT, {20'h0_0000, LINE, wy, 2'h2});
    `CHK(reg_ready_o, 1'b0)
    `CHK(core_ready_o, 1'b0)
  endtask
  task automatic core_acc(input logic w, input logic [1:0] wy, input logic [1:0] dn, input logic [19:0] t,
                          input logic [31:0] d);
    @(negedge sys_clk_i);
    core_i = {w, LINE, wy, dn, t, d};
    core_req_i = 1'b1;
    while (core_ready_o !== 1'b1) @(negedge sys_clk_i);
    @(negedge sys_clk_i);
    core_req_i = 1'b0;
    @(negedge sys_clk_i);
    `CHK(core_rvalid_o, ~w)
  endtask
  initial begin
    repeat (4) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    resetn_i = 1'b1;
    rd(S_CT, v);
    `CHK(v, 32'h0000_0000)
    rd(S_TG, v);
    `CHK(v, 32'h0000_0000)
    rd(cta_pkg::cta_sel_t'(2'h3), v);
    `CHK(v, 32'h0000_0000)
    for (int i = 0; i < 4; i++) begin
      wr(S_CT, 32'(i) << 2);
      wr(S_DA, dw[i]);
    end
    wr(S_TG, {TAGV, 12'hFD7});
    rd(S_TG, v);
    `CHK(v, {TAGV, 12'h450})
    wr(S_CT, {20'h0_0000, LINE, 2'h2, 2'h1});
    wr(S_TG, 32'h0000_0000);
    crd(2'h2);
    rd(S_DA, v);
    `CHK(v, 32'h0000_0000)
    rd(S_TG, v);
    `CHK(v, {TAGV, 12'h450})
    for (int i = 0; i < 4; i++) begin
      wr(S_CT, 32'(i) << 2);
      rd(S_DA, v);
      `CHK(v, dw[i])
    end
    core_acc(1'b0, 2'h2, 2'h1, TAGV, 32'h0000_0000);
    `CHK(core_rdata_o, dw[1])
    `CHK(core_hit_o, 1'b1)
    core_acc(1'b1, 2'h2, 2'h0, TAGV, 32'hCAFE_0001);
    core_acc(1'b0, 2'h2, 2'h1, TAGV ^ 20'h0_0001, 32'h0000_0000);
    `CHK(core_hit_o, 1'b0)
    core_acc(1'b1, 2'h1, 2'h0, TAGV, 32'h0000_0000);
    crd(2'h2);
    rd(S_TG, v);
    `CHK(v, {TAGV, 12'h6D8})
    wr(S_CT, 32'h0000_0000);
    rd(S_DA, v);
    `CHK(v, 32'hCAFE_0001)
    wr(S_CT, 32'h0000_0003);
    core_acc(1'b0, 2'h2, 2'h1, TAGV, 32'h0000_0000);
    `CHK(core_hit_o, 1'b0)
    crd(2'h2);
    rd(S_TG, v);
    `CHK(v[10], 1'b0)
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
